// ---- stack_drv_pkg.sv ----
// Purpose: Shared constants and types for the piezo stack profile driver
// Assumes: 25 MHz core clock, 16-bit register port with word addresses
// Notes: Table entries are on-time counts in 0.1 us steps
package stack_drv_pkg;

    // Clock and PWM timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int PWM_PERIOD_NS = 2000;
    localparam int DUTY_STEP_NS = 100;
    localparam int PWM_CYCLES = PWM_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [5:0] PWM_LAST = 6'(PWM_CYCLES - 1);
    localparam logic [15:0] CLK_NS_W = 16'(CLK_PERIOD_NS);
    localparam logic [15:0] STEP_NS_W = 16'(DUTY_STEP_NS);

    // Duty tables
    localparam int TABLE_DEPTH = 128;
    localparam logic [6:0] IDX_LAST = 7'(TABLE_DEPTH - 1);
    localparam logic [4:0] DUTY_FULL = 5'h14;
    localparam logic [1:0] TBL_CHARGE_A = 2'h0;
    localparam logic [1:0] TBL_DISCHARGE = 2'h3;

    // Register port
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam logic [9:0] REG_CTRL = 10'h000;
    localparam logic [9:0] REG_STACK_CFG = 10'h001;
    localparam logic [9:0] REG_VOLT = 10'h002;
    localparam logic [9:0] REG_GAP = 10'h003;
    localparam logic [9:0] REG_SOLENOID = 10'h004;
    localparam logic [9:0] REG_STATUS = 10'h005;
    localparam int TABLE_REGION_BIT = 9;
    localparam int TABLE_SEL_LSB = 7;

    // Control register bits
    localparam int CTRL_UNIT_ON = 0;
    localparam int CTRL_BOOST_ON = 1;
    localparam int CTRL_INJ_ON = 2;
    localparam int CTRL_FUEL_LSB = 3;
    localparam int CTRL_SP_MODE = 6;
    localparam int CTRL_SP_TRIG = 7;
    localparam int CTRL_CAL_REQ = 8;
    localparam int CTRL_FCLR_REQ = 9;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_PULSE_MASK = 16'h0380;

    // Stack configuration bits
    localparam int CFG_MODE = 0;
    localparam int CFG_COUNT_LSB = 1;
    localparam int CFG_SEL_LSB = 3;
    localparam logic [15:0] CFG_RESET = 16'h000A;
    localparam logic [15:0] VOLT_RESET = 16'h0000;
    localparam logic [15:0] GAP_RESET = 16'h0000;
    localparam logic [15:0] SOLENOID_RESET = 16'h0000;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHARGE = 2'b01,
        ST_HOLD = 2'b10,
        ST_DISCHARGE = 2'b11
    } stack_state_t;

endpackage

// ---- pwm_slot_timer.sv ----
// Purpose: One 2 us PWM slot timer with on-time compare
// Assumes: Duty given as count of 0.1 us steps, 0 to 20
// Notes: Slot end pulses on the last cycle of each slot
`timescale 1ns/1ps
`default_nettype none
module pwm_slot_timer (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Control
    input wire logic run_i,
    input wire logic [4:0] duty_i,
    // Results
    output logic slot_end_o,
    output logic pwm_o
);
    logic [5:0] phase_q;
    logic [5:0] phase_d;
    logic [15:0] elapsed_ns;
    logic [15:0] on_ns;

    // Phase counter wraps every slot
    always_comb begin
        phase_d = 6'h00;
        if (run_i) begin
            phase_d = (phase_q == stack_drv_pkg::PWM_LAST) ? 6'h00 : phase_q + 6'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q <= 6'h00;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Compare in ns; 0.1 us is not a whole cycle, so on-time rounds up to the next whole cycle
    assign elapsed_ns = 16'({10'h000, phase_q} * stack_drv_pkg::CLK_NS_W);
    assign on_ns = 16'({11'h000, duty_i} * stack_drv_pkg::STEP_NS_W);
    assign pwm_o = run_i && (elapsed_ns < on_ns);
    assign slot_end_o = run_i && (phase_q == stack_drv_pkg::PWM_LAST);
endmodule
`default_nettype wire

// ---- piezo_profile_pwm_driver.sv ----
// Purpose: Piezo stack driver playing charge and discharge duty tables
// Assumes: Register port and injection requests come from same-clock logic
// Notes: One stack is worked at a time; in stack mode channel 3 only ever discharges
`timescale 1ns/1ps
`default_nettype none
module piezo_profile_pwm_driver (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [9:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Injection timing and solenoid controller
    input wire logic [1:0] inj_req_i,
    input wire logic [2:0] solenoid_drive_i,
    // Channel switches
    output logic [2:0] drive_o,
    output logic stack_mode_o,
    // Controls shared with the rest of the unit
    output logic unit_on_o,
    output logic boost_supply_on_o,
    output logic injection_control_on_o,
    output logic [2:0] fuel_on_o,
    output logic single_pulse_mode_on_o,
    output logic single_pulse_trigger_o,
    output logic calibration_request_o,
    output logic fault_clear_request_o,
    output logic [7:0] idle_voltage_target_o,
    output logic [7:0] firing_voltage_target_o,
    output logic [15:0] inter_pulse_gap_o,
    output logic [15:0] solenoid_settings_o
);
    // Register file state
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] cfg_q, cfg_d;
    logic [15:0] volt_q, volt_d;
    logic [15:0] gap_q, gap_d;
    logic [15:0] sol_q, sol_d;
    logic [15:0] rdata_q, rdata_d;
    logic [2:0] pulse_q, pulse_d;
    logic fuel3_q, fuel3_d;
    logic [15:0] sol_out_q, sol_out_d;

    // Duty tables: three charge, one discharge, 128 entries each
    logic [4:0] table_mem [0:511];
    logic table_wr;
    logic [4:0] table_wval;

    // Sequencer state
    stack_drv_pkg::stack_state_t state_q, state_d;
    logic chan_q, chan_d;
    logic [6:0] idx_q, idx_d;
    logic [1:0] tbl_q, tbl_d;
    logic [2:0] drive_q, drive_d;

    // Decoded controls
    logic stack_mode;
    logic [1:0] table_count;
    logic [1:0] table_select;
    logic [1:0] charge_tbl;
    logic [1:0] fire;
    logic run;
    logic slot_end;
    logic pwm;
    logic [4:0] duty;
    logic in_table_region;

    assign stack_mode = cfg_q[stack_drv_pkg::CFG_MODE];
    assign table_count = cfg_q[stack_drv_pkg::CFG_COUNT_LSB +: 2];
    assign table_select = cfg_q[stack_drv_pkg::CFG_SEL_LSB +: 2];
    assign in_table_region = addr_i[stack_drv_pkg::TABLE_REGION_BIT];

    // Table entries are clipped so a stored count never passes full duty
    assign table_wr = wr_i && in_table_region;
    assign table_wval = (wdata_i[15:5] != 11'h000 || wdata_i[4:0] > stack_drv_pkg::DUTY_FULL)
        ? stack_drv_pkg::DUTY_FULL : wdata_i[4:0];

    always_ff @(posedge core_clk_i) begin
        if (table_wr) begin
            table_mem[addr_i[8:0]] <= table_wval;
        end
    end

    // Register writes and read data; read data stand one cycle only
    always_comb begin
        ctrl_d = ctrl_q & ~stack_drv_pkg::CTRL_PULSE_MASK;
        cfg_d = cfg_q;
        volt_d = volt_q;
        gap_d = gap_q;
        sol_d = sol_q;
        rdata_d = 16'h0000;
        if (wr_i && !in_table_region) begin
            case (addr_i)
                stack_drv_pkg::REG_CTRL: ctrl_d = wdata_i;
                stack_drv_pkg::REG_STACK_CFG: cfg_d = {11'h000, wdata_i[4:0]};
                stack_drv_pkg::REG_VOLT: volt_d = wdata_i;
                stack_drv_pkg::REG_GAP: gap_d = wdata_i;
                stack_drv_pkg::REG_SOLENOID: sol_d = wdata_i;
                default: ;
            endcase
        end
        if (rd_i) begin
            if (in_table_region) begin
                rdata_d = {11'h000, table_mem[addr_i[8:0]]};
            end else begin
                case (addr_i)
                    stack_drv_pkg::REG_CTRL: rdata_d = ctrl_q & ~stack_drv_pkg::CTRL_PULSE_MASK;
                    stack_drv_pkg::REG_STACK_CFG: rdata_d = cfg_q;
                    stack_drv_pkg::REG_VOLT: rdata_d = volt_q;
                    stack_drv_pkg::REG_GAP: rdata_d = gap_q;
                    stack_drv_pkg::REG_SOLENOID: rdata_d = sol_q;
                    stack_drv_pkg::REG_STATUS: rdata_d = {4'h0, tbl_q, idx_q, chan_q, state_q};
                    default: rdata_d = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= stack_drv_pkg::CTRL_RESET;
            cfg_q <= stack_drv_pkg::CFG_RESET;
            volt_q <= stack_drv_pkg::VOLT_RESET;
            gap_q <= stack_drv_pkg::GAP_RESET;
            sol_q <= stack_drv_pkg::SOLENOID_RESET;
            rdata_q <= 16'h0000;
            fuel3_q <= 1'b0;
            sol_out_q <= stack_drv_pkg::SOLENOID_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            volt_q <= volt_d;
            gap_q <= gap_d;
            sol_q <= sol_d;
            rdata_q <= rdata_d;
            fuel3_q <= fuel3_d;
            sol_out_q <= sol_out_d;
        end
    end

    // Masks worked out from next values, so the flopped ports change with the mode bit
    always_comb begin
        fuel3_d = ctrl_d[stack_drv_pkg::CTRL_FUEL_LSB + 2] && !cfg_d[stack_drv_pkg::CFG_MODE];
        sol_out_d = cfg_d[stack_drv_pkg::CFG_MODE] ? 16'h0000 : sol_d;
    end

    // Pick the charge table; a selection outside the enabled set falls back to the first
    always_comb begin
        charge_tbl = stack_drv_pkg::TBL_CHARGE_A;
        if (table_select != 2'h0 && table_count != 2'h0 && table_select <= table_count) begin
            charge_tbl = table_select - 2'h1;
        end
    end

    // Injection request honoured only with all the usual enables, first two channels only
    assign fire[0] = inj_req_i[0] && ctrl_q[stack_drv_pkg::CTRL_FUEL_LSB]
        && ctrl_q[stack_drv_pkg::CTRL_INJ_ON] && ctrl_q[stack_drv_pkg::CTRL_UNIT_ON];
    assign fire[1] = inj_req_i[1] && ctrl_q[stack_drv_pkg::CTRL_FUEL_LSB + 1]
        && ctrl_q[stack_drv_pkg::CTRL_INJ_ON] && ctrl_q[stack_drv_pkg::CTRL_UNIT_ON];

    // Slot timer runs only while a table is playing
    assign run = (state_q == stack_drv_pkg::ST_CHARGE) || (state_q == stack_drv_pkg::ST_DISCHARGE);
    assign duty = table_mem[{tbl_q, idx_q}];

    pwm_slot_timer u_slot (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .run_i(run),
        .duty_i(duty),
        .slot_end_o(slot_end),
        .pwm_o(pwm)
    );

    // Sequencer: charge, hold while requested, then discharge
    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        idx_d = idx_q;
        tbl_d = tbl_q;
        case (state_q)
            stack_drv_pkg::ST_IDLE: begin
                if (stack_mode && (fire != 2'b00)) begin
                    chan_d = !fire[0];
                    tbl_d = charge_tbl;
                    idx_d = 7'h00;
                    state_d = stack_drv_pkg::ST_CHARGE;
                end
            end
            stack_drv_pkg::ST_CHARGE: begin
                if (slot_end) begin
                    if (idx_q == stack_drv_pkg::IDX_LAST) begin
                        state_d = stack_drv_pkg::ST_HOLD;
                    end else begin
                        idx_d = idx_q + 7'h01;
                    end
                end
            end
            stack_drv_pkg::ST_HOLD: begin
                // Stack stays charged until its request ends
                if (!fire[chan_q]) begin
                    tbl_d = stack_drv_pkg::TBL_DISCHARGE;
                    idx_d = 7'h00;
                    state_d = stack_drv_pkg::ST_DISCHARGE;
                end
            end
            stack_drv_pkg::ST_DISCHARGE: begin
                if (slot_end) begin
                    if (idx_q == stack_drv_pkg::IDX_LAST) begin
                        state_d = stack_drv_pkg::ST_IDLE;
                        idx_d = 7'h00;
                    end else begin
                        idx_d = idx_q + 7'h01;
                    end
                end
            end
            default: state_d = stack_drv_pkg::ST_IDLE;
        endcase
    end

    // Channel switches; a running sequence always finishes before solenoid control returns
    always_comb begin
        drive_d = solenoid_drive_i;
        if (stack_mode || state_q != stack_drv_pkg::ST_IDLE) begin
            drive_d = 3'b000;
            if (state_q == stack_drv_pkg::ST_CHARGE) begin
                drive_d[chan_q] = pwm;
            end
            if (state_q == stack_drv_pkg::ST_DISCHARGE) begin
                drive_d[2] = pwm;
            end
        end
    end

    // One-cycle request pulses from write-one bits
    always_comb begin
        pulse_d = 3'b000;
        if (wr_i && !in_table_region && addr_i == stack_drv_pkg::REG_CTRL) begin
            pulse_d = {wdata_i[stack_drv_pkg::CTRL_FCLR_REQ],
                       wdata_i[stack_drv_pkg::CTRL_CAL_REQ],
                       wdata_i[stack_drv_pkg::CTRL_SP_TRIG]};
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= stack_drv_pkg::ST_IDLE;
            chan_q <= 1'b0;
            idx_q <= 7'h00;
            tbl_q <= stack_drv_pkg::TBL_CHARGE_A;
            drive_q <= 3'b000;
            pulse_q <= 3'b000;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
            idx_q <= idx_d;
            tbl_q <= tbl_d;
            drive_q <= drive_d;
            pulse_q <= pulse_d;
        end
    end

    // Outputs, all from flip-flops
    assign rdata_o = rdata_q;
    assign drive_o = drive_q;
    assign stack_mode_o = cfg_q[stack_drv_pkg::CFG_MODE];
    assign unit_on_o = ctrl_q[stack_drv_pkg::CTRL_UNIT_ON];
    assign boost_supply_on_o = ctrl_q[stack_drv_pkg::CTRL_BOOST_ON];
    assign injection_control_on_o = ctrl_q[stack_drv_pkg::CTRL_INJ_ON];
    assign fuel_on_o[1:0] = ctrl_q[stack_drv_pkg::CTRL_FUEL_LSB +: 2];
    // Third fuel enable and solenoid settings are masked while in stack mode
    assign fuel_on_o[2] = fuel3_q;
    assign solenoid_settings_o = sol_out_q;
    assign single_pulse_mode_on_o = ctrl_q[stack_drv_pkg::CTRL_SP_MODE];
    assign single_pulse_trigger_o = pulse_q[0];
    assign calibration_request_o = pulse_q[1];
    assign fault_clear_request_o = pulse_q[2];
    assign idle_voltage_target_o = volt_q[7:0];
    assign firing_voltage_target_o = volt_q[15:8];
    assign inter_pulse_gap_o = gap_q;
endmodule
`default_nettype wire

// ---- stack_drv_chk_sva.sv ----
// Purpose: Port checks for the piezo stack driver
// Assumes: One core clock, async active-low reset
// Notes: Table playback is judged by the bench model
`timescale 1ns/1ps
`default_nettype none
module stack_drv_chk (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [9:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    // Channels
    input wire logic [2:0] solenoid_drive_i,
    input wire logic [2:0] drive_o,
    input wire logic stack_mode_o,
    // Controls
    input wire logic [2:0] fuel_on_o,
    input wire logic single_pulse_trigger_o,
    input wire logic calibration_request_o,
    input wire logic [7:0] idle_voltage_target_o,
    input wire logic [7:0] firing_voltage_target_o,
    input wire logic [15:0] solenoid_settings_o
);
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    AST_TRIG_PULSE: assert property (single_pulse_trigger_o == ($past(wr_i)
        && $past(addr_i) == stack_drv_pkg::REG_CTRL && $past(wdata_i[7])))
        else $error("trigger pulse not tied to control write");
    AST_CAL_PULSE: assert property (calibration_request_o |-> $past(wr_i)
        && $past(addr_i) == stack_drv_pkg::REG_CTRL && $past(wdata_i[8]))
        else $error("calibration pulse wrong");
    AST_VOLT_LOAD: assert property ($past(wr_i) && $past(addr_i) == 10'h002
        |-> {firing_voltage_target_o, idle_voltage_target_o} == $past(wdata_i))
        else $error("voltage targets not loaded");
    AST_FUEL3_OFF: assert property (stack_mode_o |-> !fuel_on_o[2])
        else $error("third fuel enable active in stack mode");
    AST_SOL_MASK: assert property (stack_mode_o |-> solenoid_settings_o == 16'h0000)
        else $error("solenoid settings leak in stack mode");
    AST_SOL_FOLLOW: assert property (!stack_mode_o && !$past(stack_mode_o)
        |-> drive_o == $past(solenoid_drive_i))
        else $error("drive does not follow solenoid controller");
    AST_ONE_SWITCH: assert property (stack_mode_o && $past(stack_mode_o)
        |-> $onehot0(drive_o))
        else $error("more than one channel switch on");
endmodule

bind piezo_profile_pwm_driver stack_drv_chk u_chk (
    .core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .solenoid_drive_i,
    .drive_o, .stack_mode_o, .fuel_on_o, .single_pulse_trigger_o, .calibration_request_o,
    .idle_voltage_target_o, .firing_voltage_target_o, .solenoid_settings_o
);
`default_nettype wire

// ---- host_model.sv ----
// Purpose: Host-side register master for the stack driver
// Assumes: Host loop shares the core clock
// Notes: Released address and data carry inverted values
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic core_clk_i,
    // Register port
    input wire logic [15:0] rdata_i,
    output logic [9:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // Idle bus at time zero
    initial begin
        {addr_o, wdata_o, wr_o, rd_o} = 28'h0;
    end

    // One word per loop pass, loop paced by the core clock
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
    endtask

    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge core_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge core_clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask

    // No full duty early on, so a charge cannot finish too fast; entry 0 never 0
    function automatic int unsigned pick_duty(input int i);
        if (i == 0) return 1 + $urandom % 19;
        if (i < 90) return $urandom % 20;
        return $urandom % 32;
    endfunction
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the piezo stack driver
// Assumes: Host model owns the register port; bench drives requests
// Notes: Expected PWM comes from a local copy of the tables
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic sol_run = 1'b0;
    logic wr_i, rd_i, stack_mode_o, unit_on_o, boost_supply_on_o, injection_control_on_o;
    logic single_pulse_mode_on_o, single_pulse_trigger_o, calibration_request_o;
    logic fault_clear_request_o;
    logic [1:0] inj_req_i = 2'b00;
    logic [2:0] solenoid_drive_i = 3'h0, drive_o, fuel_on_o, ps;
    logic [7:0] idle_voltage_target_o, firing_voltage_target_o;
    logic [9:0] addr_i, ctl;
    logic [15:0] wdata_i, rdata_o, rv, inter_pulse_gap_o, solenoid_settings_o;
    logic [9:0] ra [4] = '{10'h000, 10'h001, 10'h006, 10'h005};
    logic [15:0] re [4] = '{16'h0000, 16'h000A, 16'h0000, 16'h0000};
    logic [15:0] cfg [4] = '{16'h000F, 16'h0015, 16'h001F, 16'h001B};
    int tsel [4] = '{0, 1, 2, 0};
    int n_mismatch = 0;
    int n_checks = 0;
    int tbl_m [4][128];
    int unsigned v;

    piezo_profile_pwm_driver dut (
        .core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .inj_req_i,
        .solenoid_drive_i, .drive_o, .stack_mode_o, .unit_on_o, .boost_supply_on_o,
        .injection_control_on_o, .fuel_on_o, .single_pulse_mode_on_o,
        .single_pulse_trigger_o, .calibration_request_o, .fault_clear_request_o,
        .idle_voltage_target_o, .firing_voltage_target_o, .inter_pulse_gap_o,
        .solenoid_settings_o
    );
    host_model host (
        .core_clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
        .wr_o(wr_i), .rd_o(rd_i)
    );

    // Control outputs gathered for one compare
    assign ctl = {unit_on_o, boost_supply_on_o, injection_control_on_o, fuel_on_o,
        single_pulse_mode_on_o, single_pulse_trigger_o, calibration_request_o,
        fault_clear_request_o};

    // 25 MHz core clock
    always #20 core_clk_i = ~core_clk_i;

    // Random solenoid drive, must be ignored in stack mode
    always @(posedge core_clk_i) if (sol_run) solenoid_drive_i <= 3'($urandom);

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Align on the first on-phase, then check every cycle of one table
    task automatic play(input int b, input int t, input bit drop);
        logic [2:0] e;
        int n;
        n = 0;
        while (drive_o[b] !== 1'b1 && n < 200) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        if (n == 200) begin
            n_mismatch++;
            test_done();
        end else begin
            for (int i = 0; i < 6400; i++) begin
                e = 3'h0;
                e[b] = (i % 50) * 40 < tbl_m[t][i / 50] * 100;
                chk("drive_o", 16'(e), 16'(drive_o));
                @(posedge core_clk_i);
                if (drop && i == 99) inj_req_i <= 2'b00;
                #1;
            end
        end
    endtask

    initial begin
        void'($urandom(14));
        repeat (8) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        // Reset values, status and an unmapped slot
        foreach (ra[k]) begin
            host.rd(ra[k], rv);
            chk("reset_read", re[k], rv);
        end
        // Solenoid mode: switches follow the solenoid controller
        sol_run <= 1'b1;
        host.wr(stack_drv_pkg::REG_SOLENOID, 16'h5A3C);
        chk("sol_set", 16'h5A3C, solenoid_settings_o);
        for (int i = 0; i < 20; i++) begin
            ps = solenoid_drive_i;
            @(posedge core_clk_i);
            #1;
            chk("follow", 16'(ps), 16'(drive_o));
        end
        // All four tables; writes above full duty clamp
        for (int t = 0; t < 4; t++) begin
            for (int i = 0; i < 128; i++) begin
                v = host.pick_duty(i);
                tbl_m[t][i] = (v > 20) ? 20 : v;
                host.wr(10'(10'h200 + t * 128 + i), 16'(v));
            end
            host.rd(10'(10'h200 + t * 128 + 127), rv);
            chk("table", 16'(tbl_m[t][127]), rv);
        end
        // Stack mode with every shared control set
        host.wr(stack_drv_pkg::REG_STACK_CFG, 16'h000F);
        chk("mode", 16'h0001, 16'(stack_mode_o));
        host.wr(stack_drv_pkg::REG_CTRL, 16'h03FF);
        chk("ctrl_out", 16'h03BF, 16'(ctl));
        @(posedge core_clk_i);
        #1;
        chk("ctrl_pulse", 16'h03B8, 16'(ctl));
        chk("sol_mask", 16'h0000, solenoid_settings_o);
        host.rd(stack_drv_pkg::REG_CTRL, rv);
        chk("ctrl_read", 16'h007F, rv);
        v = $urandom;
        host.wr(stack_drv_pkg::REG_VOLT, 16'(v));
        chk("volt", 16'(v), {firing_voltage_target_o, idle_voltage_target_o});
        host.wr(stack_drv_pkg::REG_GAP, 16'(v >> 16));
        chk("gap", 16'(v >> 16), inter_pulse_gap_o);
        // One charge and discharge per selector and count setting
        for (int r = 0; r < 4; r++) begin
            host.wr(stack_drv_pkg::REG_STACK_CFG, cfg[r]);
            @(posedge core_clk_i);
            inj_req_i <= (r == 0) ? 2'b11 : 2'(1 << (r % 2));
            play(r % 2, tsel[r], r != 0);
            if (r == 0) begin
                repeat (20) begin
                    @(posedge core_clk_i);
                    #1;
                    chk("hold", 16'h0000, 16'(drive_o));
                end
                host.rd(stack_drv_pkg::REG_STATUS, rv);
                chk("status", 16'h03FA, rv);
                @(posedge core_clk_i);
                inj_req_i <= 2'b00;
            end
            play(2, 3, 1'b0);
        end
        test_done();
    end
endmodule
`default_nettype wire
